// ### verilog/fch_pkg.sv
// fch_pkg: shared constants, classes and carriers for the fp class unit
// assumes single-precision words: sign, 8-bit biased exponent, 23-bit fraction
`default_nettype none
package fch_pkg;
   localparam int WORD_W = 32;
   localparam int EXP_W = 8;
   localparam int FRAC_W = 23;
   localparam int SIG_W = 24;
   localparam int XEXP_W = 10;
   localparam int SIGN_BIT = 31;
   localparam int QUIET_BIT = 22;
   localparam int LAT_CYC = 1;
   localparam logic [7:0] EXP_ZERO = 8'h00;
   localparam logic [7:0] EXP_MAX = 8'hff;
   localparam logic signed [10:0] EXP_MIN_OFS = 11'sh07e;
   localparam logic signed [10:0] OVF_LIMIT = 11'sh0fd;
   localparam logic [4:0] SIG_SHIFT_MAX = 5'h18;
   localparam logic [31:0] INDEF_QUIET_NOT_A_NUMBER = 32'hffc00000;
   localparam logic [31:0] RESET_WORD = 32'h00000000;

   typedef enum logic [2:0] {
      FCH_ZERO = 3'h0,
      FCH_DENORM = 3'h1,
      FCH_NORMAL = 3'h2,
      FCH_INF = 3'h3,
      FCH_QUIET_NOT_A_NUMBER = 3'h4,
      FCH_SIGNALING_NOT_A_NUMBER = 3'h5
   } fch_class_e;

   typedef struct packed {
      logic invalid;
      logic trap;
      logic den_op;
      logic underflow;
   } fch_flags_s;

   typedef struct packed {
      logic lt;
      logic eq;
      logic gt;
      logic unord;
   } fch_cmp_s;
endpackage
`default_nettype wire

// ### verilog/fch_classify.sv
// fch_classify: combinational class decode of one single-precision word
// assumes the word is stable from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module fch_classify (
   input wire logic [fch_pkg::WORD_W-1:0] opnd,
   output var fch_pkg::fch_class_e cls
);
   logic [fch_pkg::EXP_W-1:0] exp_f;
   logic [fch_pkg::FRAC_W-1:0] frac_f;

   assign exp_f = opnd[fch_pkg::SIGN_BIT-1:fch_pkg::FRAC_W];
   assign frac_f = opnd[fch_pkg::FRAC_W-1:0];

   always_comb begin
      if (exp_f == fch_pkg::EXP_ZERO) begin
         // either sign of zero lands here
         cls = (frac_f == '0) ? fch_pkg::FCH_ZERO  // RULE2
                              : fch_pkg::FCH_DENORM;  // RULE3
      end else if (exp_f == fch_pkg::EXP_MAX) begin
         // sign ignored for the not-a-number space
         if (frac_f == '0) begin
            cls = fch_pkg::FCH_INF;  // RULE8
         end else if (frac_f[fch_pkg::QUIET_BIT]) begin
            cls = fch_pkg::FCH_QUIET_NOT_A_NUMBER;  // RULE11
         end else begin
            cls = fch_pkg::FCH_SIGNALING_NOT_A_NUMBER;  // RULE12
         end
      end else begin
         cls = fch_pkg::FCH_NORMAL;  // RULE1
      end
   end
endmodule // fch_classify
`default_nettype wire

// ### verilog/fch_nan_unit.sv
// fch_nan_unit: one-stage special-value, nan-selection and denormal stage
// assumes operands, masks and policy come from pipeline logic on core_clk
//
// Functional notes
// RULE1 - biased exponent 1..254 means a normal finite operand
// RULE2 - both zero signs accepted; +0 and -0 compare equal
// RULE3 - zero exponent, nonzero fraction is denormal with integer bit 0
// RULE4 - tiny results shift right to minimum exponent; all bits out gives zero
// RULE5 - normalise whenever exponent range allows; denormal only otherwise
// RULE6 - raise underflow whenever a denormal result is created
// RULE7 - raise denormal-operand whenever any source is denormal
// RULE8 - infinity is exponent 255 with zero fraction, signed
// RULE9 - minus infinity below all finite values, plus infinity above
// RULE10 - infinities are exact; exception only if the operation is invalid
// RULE11 - max exponent with nonzero fraction is nan, sign ignored
// RULE12 - top fraction bit set is quiet nan, clear is signaling nan
// RULE13 - quiet nans pass silently; signaling nans raise invalid
// RULE14 - a signaling nan is never produced as a result
// RULE15 - signaling source with invalid unmasked: signal it, suppress write
// RULE16 - quietening sets the top fraction bit, all else unchanged
// RULE17 - invalid flag set for any signaling source even when masked
// RULE18 - invalid operation without nan sources returns the indefinite
// RULE19 - signaling plus quiet: legacy gives quiet, simd gives first quietened
// RULE20 - two signaling: legacy larger significand, simd first, quietened
// RULE21 - two quiet: legacy larger significand, simd first unchanged
// RULE22 - lone nan source is returned, quietened if signaling
// RULE23 - one quiet nan encoding is reserved as the indefinite value
// RULE24 - policy select held stable by the pipeline during each operation
`timescale 1ns/1ps
`default_nettype none
module fch_nan_unit (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic policy_simd,
   input wire logic one_operand,
   input wire logic inv_mask,
   input wire logic op_invalid,
   input wire logic [fch_pkg::WORD_W-1:0] opnd_a,
   input wire logic [fch_pkg::WORD_W-1:0] opnd_b,
   input wire logic tr_sign,
   input wire logic signed [fch_pkg::XEXP_W-1:0] tr_exp,
   input wire logic [fch_pkg::SIG_W-1:0] tr_sig,
   output logic out_valid,
   output logic write_en,
   output logic nan_hit,
   output logic [fch_pkg::WORD_W-1:0] nan_result,
   output logic [fch_pkg::WORD_W-1:0] den_result,
   output var fch_pkg::fch_class_e class_a,
   output var fch_pkg::fch_class_e class_b,
   output var fch_pkg::fch_flags_s flags,
   output var fch_pkg::fch_cmp_s cmp
);
   function automatic logic [31:0] quieten(input logic [31:0] x);
      quieten = x;
      quieten[fch_pkg::QUIET_BIT] = 1'b1;
   endfunction

   function automatic logic [4:0] lzc(input logic [23:0] s);
      lzc = 5'h18;
      for (int i = 0; i < fch_pkg::SIG_W; i++) begin
         if (s[i]) begin
            lzc = 5'(fch_pkg::SIG_W - 1 - i);
         end
      end
   endfunction

   // sign-magnitude to unsigned ordering key
   function automatic logic [31:0] okey(input logic [31:0] x);
      okey = x[31] ? ~x : {1'b1, x[30:0]};
   endfunction

   fch_pkg::fch_class_e cls_a;
   fch_pkg::fch_class_e cls_b_raw;
   fch_pkg::fch_class_e cls_b;

   fch_classify u_cls_a (
      .opnd(opnd_a),
      .cls(cls_a)
   );

   fch_classify u_cls_b (
      .opnd(opnd_b),
      .cls(cls_b_raw)
   );

   // a lone operand leaves b out of every nan and flag decision; compare still reads opnd_b
   assign cls_b = one_operand ? fch_pkg::FCH_NORMAL : cls_b_raw;

   logic a_nan, b_nan, a_sn, b_sn, any_sn;
   assign a_sn = (cls_a == fch_pkg::FCH_SIGNALING_NOT_A_NUMBER);
   assign b_sn = (cls_b == fch_pkg::FCH_SIGNALING_NOT_A_NUMBER);
   assign a_nan = a_sn || (cls_a == fch_pkg::FCH_QUIET_NOT_A_NUMBER);
   assign b_nan = b_sn || (cls_b == fch_pkg::FCH_QUIET_NOT_A_NUMBER);
   assign any_sn = a_sn || b_sn;

   // nan selection
   logic [31:0] nan_next;
   logic hit_next;
   logic inv_next;
   logic trap_next;
   logic a_larger;

   assign a_larger = (opnd_a[fch_pkg::FRAC_W-1:0]
                      >= opnd_b[fch_pkg::FRAC_W-1:0]);

   always_comb begin
      nan_next = fch_pkg::RESET_WORD;
      hit_next = 1'b0;
      if (a_nan && b_nan) begin
         hit_next = 1'b1;
         if (policy_simd) begin  // RULE24
            nan_next = quieten(opnd_a);  // RULE19 RULE20 RULE21
         end else if (a_sn != b_sn) begin
            nan_next = a_sn ? opnd_b : opnd_a;  // RULE19
         end else begin
            // ties on significand keep the first operand
            nan_next = quieten(a_larger ? opnd_a : opnd_b);  // RULE20 RULE21
         end
      end else if (a_nan) begin
         hit_next = 1'b1;
         nan_next = quieten(opnd_a);  // RULE22 RULE16
      end else if (b_nan) begin
         hit_next = 1'b1;
         nan_next = quieten(opnd_b);  // RULE22 RULE16
      end else if (op_invalid) begin
         hit_next = 1'b1;
         nan_next = fch_pkg::INDEF_QUIET_NOT_A_NUMBER;  // RULE18 RULE23
      end
   end

   // infinities alone never raise; only op_invalid or a signaling source
   assign inv_next = any_sn || (op_invalid && !a_nan && !b_nan);  // RULE10 RULE13
   assign trap_next = inv_next && !inv_mask;  // RULE15

   // gradual underflow of the true result
   logic [4:0] lz;
   logic signed [10:0] lz_s;
   logic signed [10:0] d;
   logic signed [10:0] nd;
   logic signed [10:0] biased;
   logic [23:0] sh;
   logic [31:0] den_next;
   logic tiny;

   assign lz = lzc(tr_sig);
   assign lz_s = {6'h00, lz};
   assign d = {tr_exp[fch_pkg::XEXP_W-1], tr_exp} + fch_pkg::EXP_MIN_OFS;
   assign nd = -d;
   assign biased = d - lz_s + 11'sh001;

   always_comb begin
      sh = '0;
      tiny = 1'b0;
      den_next = fch_pkg::RESET_WORD;
      if (tr_sig == '0) begin
         den_next = {tr_sign, 31'h00000000};
      end else if (d - lz_s > fch_pkg::OVF_LIMIT) begin
         den_next = {tr_sign, fch_pkg::EXP_MAX, 23'h000000};  // RULE8
      end else if (d >= lz_s) begin
         sh = tr_sig << lz;
         den_next = {tr_sign, biased[7:0], sh[22:0]};  // RULE5
      end else begin
         tiny = 1'b1;
         if (d >= 11'sh000) begin
            // room left only for a partial normalisation
            sh = tr_sig << d[4:0];  // RULE5
         end else if (nd >= 11'(fch_pkg::SIG_SHIFT_MAX)) begin
            sh = '0;  // RULE4
         end else begin
            sh = tr_sig >> nd[4:0];  // RULE4
         end
         den_next = {tr_sign, fch_pkg::EXP_ZERO, sh[22:0]};  // RULE3
      end
   end

   // comparison, affine closure
   fch_pkg::fch_cmp_s cmp_next;
   logic [31:0] ka, kb;
   assign ka = okey(opnd_a);
   assign kb = okey(opnd_b);

   always_comb begin
      cmp_next = '0;
      if (a_nan || b_nan) begin
         cmp_next.unord = 1'b1;
      end else if ((cls_a == fch_pkg::FCH_ZERO)
                   && (cls_b == fch_pkg::FCH_ZERO)) begin
         cmp_next.eq = 1'b1;  // RULE2
      end else begin
         cmp_next.lt = (ka < kb);  // RULE9
         cmp_next.eq = (ka == kb);
         cmp_next.gt = (ka > kb);  // RULE9
      end
   end

   // handshake stage
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         out_valid <= 1'b0;
         write_en <= 1'b0;
      end else begin
         out_valid <= in_valid;
         write_en <= in_valid && !trap_next;  // RULE15
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         nan_result <= fch_pkg::RESET_WORD;
         nan_hit <= 1'b0;
      end else if (in_valid) begin
         nan_result <= nan_next;  // RULE14
         nan_hit <= hit_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         den_result <= fch_pkg::RESET_WORD;
      end else if (in_valid) begin
         den_result <= den_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         class_a <= fch_pkg::FCH_ZERO;
         class_b <= fch_pkg::FCH_ZERO;
         cmp <= '0;
      end else if (in_valid) begin
         class_a <= cls_a;
         class_b <= cls_b;
         cmp <= cmp_next;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         flags <= '0;
      end else if (in_valid) begin
         flags.invalid <= inv_next;  // RULE17
         flags.trap <= trap_next;  // RULE15
         flags.den_op <= (cls_a == fch_pkg::FCH_DENORM)
                         || (cls_b == fch_pkg::FCH_DENORM);  // RULE7
         flags.underflow <= tiny;  // RULE6
      end else begin
         flags <= '0;
      end
   end

   // checks
   property p_no_signaling_not_a_number_out;  // RULE14
      @(posedge core_clk) disable iff (!rst_n)
      out_valid && nan_hit |->
         nan_result[30:23] == 8'hff && nan_result[22];
   endproperty
   a_no_signaling_not_a_number_out: assert property (p_no_signaling_not_a_number_out)  // RULE14
      else $error("signaling nan produced");

   property p_signaling_not_a_number_flag;  // RULE17
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && opnd_a[30:23] == 8'hff && !opnd_a[22]
         && opnd_a[21:0] != 22'h000000 |=> flags.invalid;
   endproperty
   a_signaling_not_a_number_flag: assert property (p_signaling_not_a_number_flag)  // RULE17
      else $error("invalid flag missed for signaling source");

   property p_trap_nowrite;  // RULE15
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && !inv_mask && opnd_a[30:22] == 9'h1fe
         && opnd_a[21:0] != 22'h000000 |=> !write_en && flags.trap;
   endproperty
   a_trap_nowrite: assert property (p_trap_nowrite)  // RULE15
      else $error("write not suppressed on trap");

   property p_simd_first;  // RULE21
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && policy_simd && opnd_a[30:22] == 9'h1ff |=>
         nan_result == $past(opnd_a);
   endproperty
   a_simd_first: assert property (p_simd_first)  // RULE21
      else $error("simd policy did not return first operand");

   property p_quiet_bit;  // RULE16
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && one_operand && a_sn |=>
         nan_result == ($past(opnd_a) | 32'h00400000);
   endproperty
   a_quiet_bit: assert property (p_quiet_bit)  // RULE16
      else $error("quietening changed more than one bit");

   property p_den_op;  // RULE7
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && opnd_a[30:23] == 8'h00 && opnd_a[22:0] != 23'h000000
         |=> flags.den_op ##1 ($past(in_valid) || flags == '0);
   endproperty
   a_den_op: assert property (p_den_op)  // RULE7
      else $error("denormal operand not flagged");

   property p_underflow;  // RULE6
      @(posedge core_clk) disable iff (!rst_n)
      out_valid && flags.underflow |-> den_result[30:23] == 8'h00;
   endproperty
   a_underflow: assert property (p_underflow)  // RULE6
      else $error("underflow without denormal result");

   property p_zero_eq;  // RULE2
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && !one_operand && opnd_a[30:0] == 31'h00000000
         && opnd_b[30:0] == 31'h00000000 |=> cmp.eq && !cmp.lt && !cmp.gt;
   endproperty
   a_zero_eq: assert property (p_zero_eq)  // RULE2
      else $error("signed zeros not equal");

   property p_ninf_low;  // RULE9
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && !one_operand && opnd_a == 32'hff800000
         && opnd_b[30:23] != 8'hff |=> cmp.lt;
   endproperty
   a_ninf_low: assert property (p_ninf_low)  // RULE9
      else $error("minus infinity not below finite");

   property p_indef;  // RULE18
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && op_invalid && !a_nan && !b_nan |=>
         nan_hit && nan_result == fch_pkg::INDEF_QUIET_NOT_A_NUMBER;
   endproperty
   a_indef: assert property (p_indef)  // RULE18
      else $error("indefinite not returned");

   property p_legacy_quiet;  // RULE19
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && !policy_simd && a_sn && b_nan && !b_sn
         |=> nan_result == $past(opnd_b);
   endproperty
   a_legacy_quiet: assert property (p_legacy_quiet)  // RULE19
      else $error("legacy policy did not return quiet source");

   // quiet sources alone must neither flag nor block the write
   property p_quiet_silent;  // RULE13
      @(posedge core_clk) disable iff (!rst_n)
      in_valid && !any_sn && !op_invalid |=> !flags.invalid && write_en;
   endproperty
   a_quiet_silent: assert property (p_quiet_silent)  // RULE13
      else $error("invalid raised without signaling source");
endmodule // fch_nan_unit
`default_nettype wire

// ### bench/fch_pipe_model.sv
// fch_pipe_model: execution pipeline stand-in feeding the nan unit
// assumes core_clk from the bench; requests launch 1 ns after an edge
`timescale 1ns/1ps
`default_nettype none
module fch_pipe_model (
   input wire logic core_clk,
   output logic in_valid,
   output logic policy_simd,
   output logic one_operand,
   output logic inv_mask,
   output logic op_invalid,
   output logic [fch_pkg::WORD_W-1:0] opnd_a,
   output logic [fch_pkg::WORD_W-1:0] opnd_b,
   output logic tr_sign,
   output logic signed [fch_pkg::XEXP_W-1:0] tr_exp,
   output logic [fch_pkg::SIG_W-1:0] tr_sig
);
   initial begin
      {in_valid, policy_simd, one_operand, inv_mask, op_invalid} = 5'h00;
      {opnd_a, opnd_b} = 64'h0;
      {tr_sign, tr_exp, tr_sig} = 35'h0;
   end
   task automatic tru(input logic s, input logic [9:0] e,
         input logic [23:0] g);
      {tr_sign, tr_exp, tr_sig} = {s, e, g};
   endtask
   // ctl = {policy, one operand, mask, op invalid}
   task automatic issue(input logic [3:0] ctl, input logic [31:0] a,
         input logic [31:0] b);
      @(posedge core_clk);
      #1;
      {policy_simd, one_operand, inv_mask, op_invalid} = ctl;
      opnd_a = a;
      opnd_b = b;
      in_valid = 1'b1;
      @(posedge core_clk);
      #1;
      // released lines show junk so stale values cannot pass
      in_valid = 1'b0;
      opnd_a = ~a;
      opnd_b = ~b;
      policy_simd = ~policy_simd;
   endtask
endmodule // fch_pipe_model
`default_nettype wire

// ### bench/fch_nan_unit_tb.sv
// fch_nan_unit_tb: self-checking bench for the nan unit
// assumes one-cycle latency; results checked 1 ns after the taking edge
`timescale 1ns/1ps
`default_nettype none
module fch_nan_unit_tb;
   logic core_clk, rst_n, in_valid, policy_simd, one_operand, inv_mask;
   logic op_invalid, tr_sign, out_valid, write_en, nan_hit;
   logic [31:0] opnd_a, opnd_b, nan_result, den_result;
   logic signed [9:0] tr_exp;
   logic [23:0] tr_sig;
   fch_pkg::fch_class_e class_a, class_b;
   fch_pkg::fch_flags_s flags;
   fch_pkg::fch_cmp_s cmp;
   int bad_count = 0;
   int n_tests = 0;

   fch_pipe_model pipe (.core_clk, .in_valid, .policy_simd, .one_operand,
      .inv_mask, .op_invalid, .opnd_a, .opnd_b, .tr_sign, .tr_exp, .tr_sig);
   fch_nan_unit uut (.core_clk, .rst_n, .in_valid, .policy_simd,
      .one_operand, .inv_mask, .op_invalid, .opnd_a, .opnd_b, .tr_sign,
      .tr_exp, .tr_sig, .out_valid, .write_en, .nan_hit, .nan_result,
      .den_result, .class_a, .class_b, .flags, .cmp);

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic t_class;
      logic [31:0] w [8] = '{32'h00000000, 32'h80000000, 32'h00000001,
         32'h00800000, 32'h7f7fffff, 32'hff800000, 32'hffc00000,
         32'h7f800001};
      logic [2:0] c [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h5};
      for (int i = 0; i < 8; i++) begin
         pipe.issue(4'h2, w[i], w[7-i]);
         chk(32'(out_valid), 32'h1);
         chk(32'(class_a), 32'(c[i]));
         chk(32'(class_b), 32'(c[7-i]));
         chk(32'(flags.den_op), 32'(c[i] == 1 || c[7-i] == 1));
      end
   endtask

   task automatic t_cmp;
      logic [31:0] a [4] = '{32'h00000000, 32'hff800000, 32'h7f800000,
         32'h7fc00000};
      logic [31:0] b [4] = '{32'h80000000, 32'hff7fffff, 32'h7f7fffff,
         32'h3f800000};
      logic [3:0] r [4] = '{4'h4, 4'h8, 4'h2, 4'h1};
      for (int i = 0; i < 4; i++) begin
         pipe.issue(4'h2, a[i], b[i]);
         chk(32'(cmp), 32'(r[i]));
      end
   endtask

   // masked invalid; both policies over the nan pairings
   task automatic t_nan;
      logic [3:0] k [8] = '{4'h2, 4'ha, 4'h2, 4'ha, 4'h2, 4'ha, 4'h2, 4'he};
      logic [31:0] a [8] = '{32'h7f800005, 32'h7f800005, 32'h7f800005,
         32'h7f800005, 32'h7fc00001, 32'h7fc00001, 32'h7f800005,
         32'hffc00007};
      logic [31:0] b [8] = '{32'h7fc00002, 32'h7fc00002, 32'hff800009,
         32'hff800009, 32'hffc00002, 32'hffc00002, 32'h3f800000,
         32'h7f800001};
      logic [31:0] r [8] = '{32'h7fc00002, 32'h7fc00005, 32'hffc00009,
         32'h7fc00005, 32'hffc00002, 32'h7fc00001, 32'h7fc00005,
         32'hffc00007};
      logic v [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 8; i++) begin
         pipe.issue(k[i], a[i], b[i]);
         chk(nan_result, r[i]);
         chk(32'({nan_hit, write_en, flags.trap}), 32'h6);
         chk(32'(flags.invalid), 32'(v[i]));
      end
   endtask

   task automatic t_trap;
      pipe.issue(4'h0, 32'h7fa00000, 32'h3f800000);
      chk(32'({write_en, flags.trap, flags.invalid}), 32'h3);
      pipe.issue(4'h0, 32'h7fc00000, 32'h3f800000);
      chk(32'({write_en, flags.trap, flags.invalid}), 32'h4);
      // lone signaling source; b carries a signaling value that must be ignored
      pipe.issue(4'h6, 32'h7fa00000, 32'h7f800001);
      chk(nan_result, 32'h7fe00000);
      chk(32'({class_a, class_b}), 32'h2a);
      chk(32'({write_en, flags.trap, flags.invalid}), 32'h5);
      pipe.issue(4'h4, 32'h7fa00000, 32'h3f800000);
      chk(32'({write_en, flags.trap, flags.invalid}), 32'h3);
      pipe.issue(4'h3, 32'h7f800000, 32'hff800000);
      chk(nan_result, 32'hffc00000);
      chk(32'({nan_hit, flags.invalid}), 32'h3);
      pipe.issue(4'h2, 32'h7f800000, 32'h3f800000);
      chk(32'({nan_hit, flags.invalid}), 32'h0);
   endtask

   // tr_exp values are signed: 37f=-129 382=-126 338=-200 080=128
   task automatic t_den;
      logic [9:0] e [6] = '{10'h37f, 10'h382, 10'h000, 10'h338, 10'h080,
         10'h382};
      logic [23:0] g [6] = '{24'hae0000, 24'h800000, 24'h400000,
         24'h800000, 24'h800000, 24'h400000};
      logic [31:0] r [6] = '{32'h8015c000, 32'h00800000, 32'h3f000000,
         32'h00000000, 32'h7f800000, 32'h00400000};
      logic u [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 6; i++) begin
         pipe.tru(i == 0, e[i], g[i]);
         pipe.issue(4'h2, 32'h3f800000, 32'h3f800000);
         chk(den_result, r[i]);
         chk(32'(flags.underflow), 32'(u[i]));
      end
   endtask

   initial begin
      rst_n = 1'b0;
      repeat (4) @(posedge core_clk);
      #1;
      chk(nan_result | den_result, 32'h0);
      chk(32'({out_valid, write_en, nan_hit, flags, cmp, class_a}), 32'h0);
      rst_n = 1'b1;
      t_class;
      t_cmp;
      t_nan;
      t_trap;
      t_den;
      complete_run;
   end

   // hang guard
   initial begin
      repeat (5000) @(posedge core_clk);
      bad_count++;
      complete_run;
   end
endmodule // fch_nan_unit_tb
`default_nettype wire
